// ---- logic/ppc_consts.vh ----
// Purpose: constants for the parallel port line control block
// Assumes: one aligned 32-bit word per register on AXI4-Lite
// Notes: offsets are byte addresses chosen for this block
`ifndef PPC_CONSTS_VH
`define PPC_CONSTS_VH
// register byte offsets
`define PPC_OFS_LINE_CTRL 4'h0
`define PPC_OFS_PORT_CFG 4'h4
`define PPC_OFS_EVENT 4'h8
// field positions in port_line_control
`define PPC_BIT_STROBE 0
`define PPC_BIT_AUTOFEED 1
`define PPC_BIT_PRST 2
`define PPC_BIT_SELIN 3
`define PPC_BIT_IRQEN 4
`define PPC_BIT_DIR 5
// field positions in port configuration word
`define PPC_CFG_MODE_LSB 0
`define PPC_CFG_MODE_MSB 2
`define PPC_CFG_SLAVE 3
`define PPC_CFG_LEVEL 4
`define PPC_CFG_PINDIS 5
// operating modes
`define PPC_MODE_SPP 3'h0
`define PPC_MODE_PS2 3'h1
`define PPC_MODE_FIFO 3'h2
`define PPC_MODE_ECP 3'h3
// reset values
`define PPC_RST_LINE_CTRL 6'h00
`define PPC_RST_CFG 6'h20
// bus responses
`define PPC_RESP_OKAY 2'h0
`define PPC_RESP_SLVERR 2'h2
`endif

// ---- logic/ppc_edge_det.v ----
// Purpose: rising-edge detector for one synchronous input
// Assumes: input already synchronous to aclk
// Notes: pulse is one cycle wide, registered
`timescale 1ns/10ps
module ppc_edge_det (
  input wire aclk,
  input wire aresetn,
  input wire sig_in,
  output reg rise_p
);
  reg prev_r;

  // ----------------------------------------
  // previous sample and edge pulse
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b1;
      rise_p <= 1'b0;
    end else begin
      prev_r <= sig_in;
      rise_p <= sig_in & ~prev_r;
    end
  end
endmodule // ppc_edge_det

// ---- logic/ppc_line_ctrl.v ----
// Purpose: control bits and handshake lines of a 1284 parallel port, AXI4-Lite slave
// Assumes: pins synchronous to aclk; mode, slave and pin-disable set by software
// Notes: interrupt request is a port level or pulse, never floated
`timescale 1ns/10ps
`include "ppc_consts.vh"
module ppc_line_ctrl (
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // hardware line requests from the transfer engine
  input wire hw_strobe_n,
  input wire hw_auto_feed_n,
  // handshake pins, input / output / enable
  input wire select_in_line_i,
  output reg select_in_line_o,
  output reg select_in_line_oe,
  input wire periph_reset_line_i,
  output reg periph_reset_line_o,
  output reg periph_reset_line_oe,
  input wire auto_feed_line_i,
  output reg auto_feed_line_o,
  output reg auto_feed_line_oe,
  input wire data_strobe_line_i,
  output reg data_strobe_line_o,
  output reg data_strobe_line_oe,
  input wire ack_line_n,
  // data lines drive enable and direction
  output reg port_data_lines_oe,
  output reg dir_reverse,
  // interrupt request
  output reg irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [5:0] ctrl_r;
  reg [5:0] cfg_r;
  reg ack_pend_r;
  reg stb_pend_r;
  reg wr_aw_r;
  reg wr_w_r;
  reg [3:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  wire ack_rise;
  wire stb_rise;
  wire [2:0] mode;
  wire slave;
  wire level_irq;
  wire pin_dis;
  wire dir_forced;
  wire host_ecp;
  wire host_fifo;
  wire do_write;
  wire wr_ctrl;
  wire wr_cfg;
  wire wr_evt;
  wire [5:0] ctrl_nxt;
  wire irqen_nxt;
  reg [5:0] ctrl_view;
  reg [31:0] rdata_nxt;
  reg rresp_nxt;

  // ----------------------------------------
  // register word indices
  // ----------------------------------------
  // only bits 3:2 pick a word; the byte lanes below them are not decoded
  localparam [3:0] OFS_CTRL = `PPC_OFS_LINE_CTRL;
  localparam [3:0] OFS_CFG = `PPC_OFS_PORT_CFG;
  localparam [3:0] OFS_EVT = `PPC_OFS_EVENT;
  localparam [1:0] IDX_CTRL = OFS_CTRL[3:2];
  localparam [1:0] IDX_CFG = OFS_CFG[3:2];
  localparam [1:0] IDX_EVT = OFS_EVT[3:2];

  assign mode = cfg_r[`PPC_CFG_MODE_MSB:`PPC_CFG_MODE_LSB];
  assign slave = cfg_r[`PPC_CFG_SLAVE];
  assign level_irq = cfg_r[`PPC_CFG_LEVEL];
  assign pin_dis = cfg_r[`PPC_CFG_PINDIS];
  assign dir_forced = (mode == `PPC_MODE_SPP) || (mode == `PPC_MODE_FIFO);
  assign host_ecp = !slave && (mode == `PPC_MODE_ECP);
  assign host_fifo = !slave && (mode == `PPC_MODE_FIFO);

  // ----------------------------------------
  // edge detectors: ack release and strobe release
  // ----------------------------------------
  // both lines idle high, so the detectors reset high to avoid a false edge
  ppc_edge_det u_ack_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig_in(ack_line_n),
    .rise_p(ack_rise)
  );

  ppc_edge_det u_stb_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig_in(data_strobe_line_i),
    .rise_p(stb_rise)
  );

  // ----------------------------------------
  // write channel capture
  // ----------------------------------------
  // address and data accepted in either order; response once both held
  assign do_write = wr_aw_r && wr_w_r && !s_axi_bvalid;
  assign wr_ctrl = do_write && (awaddr_r[3:2] == IDX_CTRL) && wstrb_r[0];
  assign wr_cfg = do_write && (awaddr_r[3:2] == IDX_CFG) && wstrb_r[0];
  assign wr_evt = do_write && (awaddr_r[3:2] == IDX_EVT) && wstrb_r[0];

  // readies stay low until the response is taken, so a second write waits
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPC_RESP_OKAY;
      wr_aw_r <= 1'b0;
      wr_w_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        wr_aw_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        wr_w_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r[3:2] == 2'h3) ? `PPC_RESP_SLVERR : `PPC_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        wr_aw_r <= 1'b0;
        wr_w_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // control and configuration registers
  // ----------------------------------------
  // direction write dropped while forced; held at 0 when mode forces it
  assign ctrl_nxt = {(dir_forced ? 1'b0 : wdata_r[`PPC_BIT_DIR]),
                     wdata_r[`PPC_BIT_IRQEN:0]};
  assign irqen_nxt = wr_ctrl ? wdata_r[`PPC_BIT_IRQEN] : ctrl_r[`PPC_BIT_IRQEN];

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `PPC_RST_LINE_CTRL;
      cfg_r <= `PPC_RST_CFG;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= ctrl_nxt;
      end else if (dir_forced) begin
        ctrl_r[`PPC_BIT_DIR] <= 1'b0;
      end
      // a mode change acts on the pins one edge after it lands
      if (wr_cfg) begin
        cfg_r <= wdata_r[5:0];
      end
    end
  end

  // ----------------------------------------
  // interrupt sources
  // ----------------------------------------
  // set beats clear; pending cleared by write-one to event reg.
  // a level request dies with its enable; pulse mode needs no pending
  always @(posedge aclk) begin
    if (!aresetn) begin
      ack_pend_r <= 1'b0;
      stb_pend_r <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (!slave && ctrl_r[`PPC_BIT_IRQEN] && ack_rise) begin
        ack_pend_r <= 1'b1;
      end else if ((wr_evt && wdata_r[0]) || (level_irq && !irqen_nxt)) begin
        ack_pend_r <= 1'b0;
      end
      // strobe events only count while the remote host owns the lines and the mode field is SPP
      if (slave && (mode == `PPC_MODE_SPP) && ctrl_r[`PPC_BIT_IRQEN] && stb_rise) begin
        stb_pend_r <= 1'b1;
      end else if ((wr_evt && wdata_r[1]) || (level_irq && !irqen_nxt)) begin
        stb_pend_r <= 1'b0;
      end
      // irq is always driven, only its level changes
      if (level_irq) begin
        irq <= ack_pend_r || stb_pend_r;
      end else begin
        irq <= (!slave && ctrl_r[`PPC_BIT_IRQEN] && ack_rise)
               || (slave && (mode == `PPC_MODE_SPP) && ctrl_r[`PPC_BIT_IRQEN] && stb_rise);
      end
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // from ctrl_nxt on the write so a control-line pin moves at the edge the write lands; direction and data enable follow ctrl_r
  always @(posedge aclk) begin
    if (!aresetn) begin
      select_in_line_o <= 1'b1;
      select_in_line_oe <= 1'b0;
      periph_reset_line_o <= 1'b0;
      periph_reset_line_oe <= 1'b1;
      auto_feed_line_o <= 1'b1;
      auto_feed_line_oe <= 1'b0;
      data_strobe_line_o <= 1'b1;
      data_strobe_line_oe <= 1'b0;
      port_data_lines_oe <= 1'b0;
      dir_reverse <= 1'b0;
    end else if (pin_dis) begin
      // drivers released except reset, which is driven low; the released ones keep their level for a clean re-enable
      select_in_line_oe <= 1'b0;
      auto_feed_line_oe <= 1'b0;
      data_strobe_line_oe <= 1'b0;
      periph_reset_line_o <= 1'b0;
      periph_reset_line_oe <= 1'b1;
      port_data_lines_oe <= 1'b0;
      dir_reverse <= ctrl_r[`PPC_BIT_DIR];
    end else begin
      dir_reverse <= ctrl_r[`PPC_BIT_DIR];
      port_data_lines_oe <= slave ? ctrl_r[`PPC_BIT_DIR] : !ctrl_r[`PPC_BIT_DIR];
      // slave mode: the remote host owns all four control lines
      select_in_line_oe <= !slave;
      periph_reset_line_oe <= !slave;
      auto_feed_line_oe <= !slave;
      data_strobe_line_oe <= !slave;
      select_in_line_o <= !ctrl_view[`PPC_BIT_SELIN];
      periph_reset_line_o <= ctrl_view[`PPC_BIT_PRST];
      // shared lines: hardware may pull low while software bit is 0
      auto_feed_line_o <= !ctrl_view[`PPC_BIT_AUTOFEED]
                          && (!host_ecp || hw_auto_feed_n);
      data_strobe_line_o <= !ctrl_view[`PPC_BIT_STROBE]
                            && (!(host_ecp || host_fifo) || hw_strobe_n);
    end
  end

  // ----------------------------------------
  // value in effect for pin drive
  // ----------------------------------------
  // bypass so a write reaches its pin at the same edge as the register
  always @* begin
    ctrl_view = ctrl_r;
    if (wr_ctrl) begin
      ctrl_view = ctrl_nxt;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  // slave and standard mode show live lines; otherwise last written
  always @* begin
    rdata_nxt = 32'h00000000;
    rresp_nxt = 1'b0;
    case (s_axi_araddr[3:2])
      IDX_CTRL: begin
        rdata_nxt[5:0] = ctrl_r;
        if (slave || (mode == `PPC_MODE_SPP)) begin
          rdata_nxt[`PPC_BIT_SELIN] = !select_in_line_i;
          rdata_nxt[`PPC_BIT_PRST] = periph_reset_line_i;
          rdata_nxt[`PPC_BIT_AUTOFEED] = !auto_feed_line_i;
          rdata_nxt[`PPC_BIT_STROBE] = !data_strobe_line_i;
        end
      end
      IDX_CFG: begin
        rdata_nxt[5:0] = cfg_r;
      end
      IDX_EVT: begin
        rdata_nxt[2:0] = {irq, stb_pend_r, ack_pend_r};
      end
      default: begin
        rresp_nxt = 1'b1;
      end
    endcase
  end

  // data is taken at the address handshake, so live pins are one cycle old
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PPC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_nxt;
        s_axi_rresp <= rresp_nxt ? `PPC_RESP_SLVERR : `PPC_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // ppc_line_ctrl

// ---- tb/ppc_far_end.sv ----
// Purpose: far side of the cable, printer or remote host
// Assumes: lines ordered select-in, reset, auto-feed, strobe
// Notes: released lines float high through cable pull-ups
`timescale 1ns/10ps
module ppc_far_end (
  input wire drive,
  input wire [3:0] lv,
  input wire [3:0] po,
  input wire [3:0] poe,
  output wire [3:0] pi
);
  // our pins win; remote host drives only as a slave partner
  assign pi = (poe & po) | (~poe & (drive ? lv : 4'hF));
endmodule // ppc_far_end

// ---- tb/ppc_line_ctrl_monitor.sv ----
// Purpose: concurrent checks on the line control block ports
// Assumes: one clock domain, synchronous active-low reset
// Notes: shadows the config and line words as write responses are taken
`timescale 1ns/10ps
module ppc_line_ctrl_monitor (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire select_in_line_o,
  input wire select_in_line_oe,
  input wire periph_reset_line_o,
  input wire periph_reset_line_oe,
  input wire auto_feed_line_o,
  input wire auto_feed_line_oe,
  input wire data_strobe_line_o,
  input wire data_strobe_line_oe,
  input wire data_strobe_line_i,
  input wire ack_line_n,
  input wire port_data_lines_oe,
  input wire dir_reverse,
  input wire irq
);
  logic [3:0] adr_r;
  logic [5:0] wd_r;
  logic [5:0] cfg_r;
  logic [5:0] lc_r;
  logic ws_r;
  wire hs = s_axi_bvalid && s_axi_bready && ws_r;
  // shadow copies; updated at the response handshake, one edge after the register
  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= 6'h20;
      lc_r <= 6'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) adr_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[5:0];
      if (s_axi_wvalid && s_axi_wready) ws_r <= s_axi_wstrb[0];
      if (hs && adr_r == 4'h4) cfg_r <= wd_r;
      if (hs && adr_r == 4'h0) lc_r <= wd_r;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  sequence line_wr;
    hs && adr_r == 4'h0 && !cfg_r[5] && cfg_r[3:1] == 3'h0;
  endsequence
  sequence ack_rise;
    $rose(ack_line_n) && lc_r[4] && !cfg_r[3];
  endsequence
  sequence stb_rise;
    $rose(data_strobe_line_i) && lc_r[4] && cfg_r[3] && cfg_r[2:0] == 3'h0;
  endsequence
  chk_reset_pins: assert property ($rose(aresetn) |->
    !select_in_line_oe && !auto_feed_line_oe && !data_strobe_line_oe
    && periph_reset_line_oe && !periph_reset_line_o && !irq) else $error("pins wrong after reset");
  chk_sel_drive: assert property (line_wr |=>
    select_in_line_oe && select_in_line_o == !wd_r[3]) else $error("select-in pin wrong");
  chk_prst_drive: assert property (line_wr |=>
    periph_reset_line_oe && periph_reset_line_o == wd_r[2]) else $error("reset pin wrong");
  chk_feed_drive: assert property (line_wr |=>
    auto_feed_line_oe && auto_feed_line_o == !wd_r[1]) else $error("auto-feed pin wrong");
  chk_stb_drive: assert property (line_wr |=>
    data_strobe_line_oe && data_strobe_line_o == !wd_r[0]) else $error("strobe pin wrong");
  chk_dir_forced: assert property (hs && adr_r == 4'h0 && cfg_r[1:0] != 2'h1
    && cfg_r[2:0] < 3'h3 |=> !dir_reverse) else $error("direction not forced");
  chk_data_oe: assert property (line_wr ##0 cfg_r[2:0] == 3'h1 |=>
    dir_reverse == wd_r[5] && port_data_lines_oe == !wd_r[5]) else $error("data drive wrong");
  chk_irq_cancel: assert property (line_wr ##0 (cfg_r[4] && !wd_r[4]) |->
    ##[1:2] !irq) else $error("irq not cancelled");
  chk_ack_irq: assert property (ack_rise |-> ##[1:3] irq)
    else $error("no ack irq");
  chk_stb_irq: assert property (stb_rise |-> ##[1:3] irq)
    else $error("no strobe irq");
endmodule // ppc_line_ctrl_monitor

bind ppc_line_ctrl ppc_line_ctrl_monitor mon_u (.*);

// ---- tb/ppc_line_ctrl_tb.sv ----
// Purpose: self-checking bench for the line control block
// Assumes: bready and rready held until the answer
// Notes: ack line is pulsed by the bench in the printer's place
`timescale 1ns/10ps
module ppc_line_ctrl_tb;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic hw_strobe_n = 1'b1, hw_auto_feed_n = 1'b1, ack_line_n = 1'b1, drv = 1'b0;
  logic [3:0] lv = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire select_in_line_i, select_in_line_o, select_in_line_oe;
  wire periph_reset_line_i, periph_reset_line_o, periph_reset_line_oe;
  wire auto_feed_line_i, auto_feed_line_o, auto_feed_line_oe;
  wire data_strobe_line_i, data_strobe_line_o, data_strobe_line_oe;
  wire port_data_lines_oe, dir_reverse, irq;
  wire [3:0] po = {select_in_line_o, periph_reset_line_o, auto_feed_line_o, data_strobe_line_o};
  wire [3:0] poe = {select_in_line_oe, periph_reset_line_oe, auto_feed_line_oe,
    data_strobe_line_oe};
  int miscompares = 0, comparisons = 0;
  ppc_line_ctrl dut_u (.*);
  ppc_far_end far_u (.drive(drv), .lv(lv), .po(po), .poe(poe), .pi({select_in_line_i,
    periph_reset_line_i, auto_feed_line_i, data_strobe_line_i}));
  always #25 aclk = ~aclk;
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task complete_run;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      miscompares++;
      complete_run();
    end
  endtask
  // write: offer address and data together, drop each when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    tmo(n);
    // the unused word answers with an error, every other offset with okay
    cmp({30'h0, s_axi_bresp}, {30'h0, (a == 4'hC) ? 2'h2 : 2'h0});
  endtask
  // read and judge data (only on OKAY) and response
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    tmo(n);
    if (er == 2'h0) cmp(s_axi_rdata, e);
    cmp({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic pk(input logic [7:0] e);
    @(posedge aclk);
    cmp({24'h0, poe, po}, {24'h0, e});
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
    rd(4'h0, 32'h0, 2'h0);
    rd(4'h4, 32'h20, 2'h0);
    pk(8'h4B);
    rd(4'hC, 32'h0, 2'h2);
    wr(4'hC, 32'h0);
  endtask
  task t_host;
    wr(4'h4, 32'h0);
    wr(4'h0, 32'h0F);
    pk(8'hF4);
    rd(4'h0, 32'h0F, 2'h0);
    wr(4'h0, 32'h04);
    pk(8'hFF);
    rd(4'h0, 32'h04, 2'h0);
  endtask
  task t_dir;
    wr(4'h0, 32'h20);
    rd(4'h0, 32'h0, 2'h0);
    wr(4'h4, 32'h1);
    wr(4'h0, 32'h20);
    pk(8'hFB);
    cmp({30'h0, dir_reverse, port_data_lines_oe}, 32'h2);
    rd(4'h0, 32'h20, 2'h0);
    wr(4'h0, 32'h08);
    pk(8'hF3);
    cmp({30'h0, dir_reverse, port_data_lines_oe}, 32'h1);
  endtask
  // hardware requests need one edge to reach the registered pins
  task t_ecp;
    wr(4'h4, 32'h3);
    wr(4'h0, 32'h0C);
    hw_strobe_n <= 1'b0;
    hw_auto_feed_n <= 1'b0;
    @(posedge aclk);
    pk(8'hF4);
    rd(4'h0, 32'h0C, 2'h0);
    wr(4'h4, 32'h2);
    pk(8'hF6);
    hw_strobe_n <= 1'b1;
    hw_auto_feed_n <= 1'b1;
  endtask
  task t_irq;
    int n;
    wr(4'h4, 32'h10);
    wr(4'h0, 32'h10);
    ack_line_n <= 1'b0;
    repeat (3) @(posedge aclk);
    ack_line_n <= 1'b1;
    repeat (4) @(posedge aclk);
    cmp({31'h0, irq}, 32'h1);
    rd(4'h8, 32'h5, 2'h0);
    wr(4'h0, 32'h0);
    repeat (2) @(posedge aclk);
    cmp({31'h0, irq}, 32'h0);
    rd(4'h8, 32'h0, 2'h0);
    // pulse mode: one-cycle request, pending kept until written off
    wr(4'h4, 32'h0);
    wr(4'h0, 32'h10);
    ack_line_n <= 1'b0;
    @(posedge aclk);
    ack_line_n <= 1'b1;
    n = 0;
    repeat (6) begin
      @(posedge aclk);
      if (irq === 1'b1) n++;
    end
    cmp(n, 32'h1);
    rd(4'h8, 32'h1, 2'h0);
    wr(4'h8, 32'h1);
    rd(4'h8, 32'h0, 2'h0);
  endtask
  task t_slave;
    int n;
    wr(4'h4, 32'h08);
    drv <= 1'b1;
    lv <= 4'h6;
    rd(4'h0, 32'h1D, 2'h0);
    wr(4'h0, 32'h10);
    lv <= 4'h7;
    for (n = 0; n < 8; n++) begin
      @(posedge aclk);
      if (irq === 1'b1) break;
    end
    cmp({31'h0, n < 8}, 32'h1);
    // slave in reverse drives the data lines
    wr(4'h4, 32'h09);
    wr(4'h0, 32'h20);
    @(posedge aclk);
    cmp({30'h0, dir_reverse, port_data_lines_oe}, 32'h3);
    drv <= 1'b0;
  endtask
  // reset for 20 cycles, then the scenarios in turn
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_host();
    t_dir();
    t_ecp();
    t_irq();
    t_slave();
    // second reset in mid-run: all that was written must be cleared
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    complete_run();
  end
endmodule // ppc_line_ctrl_tb
